/* File: led_seq_pkg.sv */
/*
 Shared constants and types for the LED string fault sequencer.
 Assumes a 20 MHz core clock; all times are derived from CLK_MHZ.
*/
`default_nettype none
package led_seq_pkg;
   localparam int CLK_MHZ      = 20;
   localparam int NCH          = 6;
   localparam int CW           = 20;
   localparam int SW           = 10;
   localparam int QUAL_US      = 40;
   localparam int QUAL_CYC     = QUAL_US * CLK_MHZ;
   localparam int IDLE_MS      = 28;
   localparam int IDLE_CYC     = IDLE_MS * 1000 * CLK_MHZ;
   localparam int SS_US        = 1000;
   localparam int SS_STEPS     = 7;
   localparam int SS_STEP_CYC  = SS_US * CLK_MHZ / SS_STEPS;
   localparam int LIMIT_STEP_MA = 375;
   localparam int OPEN_US      = 6000;
   localparam int OPEN_CYC     = OPEN_US * CLK_MHZ;
   localparam int OPEN_HOT_US  = 800;
   localparam int OPEN_HOT_CYC = OPEN_HOT_US * CLK_MHZ;
   localparam int SENSE_LSB_MV = 50;
   localparam int SHORT_MV     = 8000;
   localparam int SHORT_CODE   = SHORT_MV / SENSE_LSB_MV;

   typedef enum logic [4:0] {
      S_OFF    = 5'h01,
      S_QUAL   = 5'h02,
      S_INRUSH = 5'h04,
      S_SOFT   = 5'h08,
      S_RUN    = 5'h10
   } seq_e;

   typedef struct packed {
      logic overVolt;
      logic hotLow;
      logic inOverCur;
      logic ledStable;
   } prot_s;

   typedef struct packed {
      logic [NCH-1:0] good;
      logic [NCH-1:0] open;
      logic [NCH-1:0] off;
   } chanStat_s;
endpackage
`default_nettype wire

/* File: led_string_fault_sequencer.sv */
/*
 Enable qualification, soft-start and per-channel fault sequencing for a
 six-string LED boost driver. Analog comparisons arrive as synchronous
 digital codes and flags; supply lockout acts as a synchronous reset.
*/
// What this block does
// - First high pulse of at least 40us on the dimming input enables operation.
// - Dimming input idle longer than 28ms forces shutdown.
// - Channel current is chopped by the dimming input, giving set current times duty.
// - Boost switching starts only once the fault switch is fully on.
// - Switching ends for the cycle whenever switch current exceeds the present limit.
// - Soft-start limit starts at 375mA, rising seven 375mA steps to 3A.
// - The soft-start steps span 1ms, so 3A holds from 1ms on.
// - Lowest channel sense voltage is feedback when below the short threshold.
// - A channel sensed above 8V is disabled as shorted.
// - A channel reaching 75% of target current is marked good.
// - A good channel falling below 50% of target is flagged open.
// - Overvoltage or low over-temperature flags every not-good channel open at once.
// - Open channels are disabled after a time-out, shorter when hot.
// - Current and short fault declarations wait for stable LED feedback; overvoltage or hot open flags do not.
// - Disabling one channel leaves the others running.
// - Input overcurrent shuts down all output channels.
// - The hot open time-out is 800us.
// - Supply lockout stops switching and resets; restart follows recovery.
`default_nettype none
module led_string_fault_sequencer
   import led_seq_pkg::*;
#(
   parameter int IDLE_P     = IDLE_CYC,
   parameter int SS_STEP_P  = SS_STEP_CYC,
   parameter int OPEN_P     = OPEN_CYC,
   parameter int OPEN_HOT_P = OPEN_HOT_CYC
) (
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire logic                   clkEn,
   input  wire logic                   supplyLockout,
   input  wire logic                   enableDimming,
   input  wire logic                   faultSwitchOn,
   input  wire logic [11:0]            switchCurMa,
   input  wire prot_s                  prot,
   input  wire logic [NCH-1:0][SW-1:0] senseCode,
   input  wire logic [SW-1:0]          shortThr,
   input  wire logic [NCH-1:0]         above75,
   input  wire logic [NCH-1:0]         below50,
   output var  logic                   gateSink_q,
   output var  logic                   boostRun_q,
   output var  logic [11:0]            limitMa_q,
   output var  logic                   cycleOff_q,
   output var  logic [NCH-1:0]         chanOn_q,
   output var  logic [SW-1:0]          fbCode_q,
   output var  logic                   fbValid_q,
   output var  chanStat_s              stat_q
);

   // Lockout behaves exactly like reset so every counter and flag restarts.
   logic    rstAll;
   assign rstAll = rst | supplyLockout;

   seq_e           st_q, st_d;
   logic [CW-1:0]  cnt_q, cnt_d;
   logic [CW-1:0]  idle_q, idle_d;
   logic [2:0]     step_q, step_d;
   logic           idleOut;
   logic           gateSink_d, boostRun_d, cycleOff_d, fbValid_d;
   logic [11:0]    limitMa_d;

   assign idleOut = idle_q >= CW'(IDLE_P);

   // Sequencer: qualify, inrush wait, stepped soft-start, run.
   always_comb begin
      st_d   = st_q;
      cnt_d  = cnt_q;
      step_d = step_q;
      // Only a low level counts as idle; a steady high is full brightness.
      if (enableDimming) begin
         idle_d = '0;
      end else if (!idleOut) begin
         idle_d = idle_q + CW'(1);
      end else begin
         idle_d = idle_q;
      end
      unique case (st_q)
         S_OFF: begin
            cnt_d = CW'(1);
            if (enableDimming) begin
               st_d = S_QUAL;
            end
         end
         S_QUAL: begin
            cnt_d = cnt_q + CW'(1);
            if (!enableDimming) begin
               st_d = S_OFF;
            end else if (cnt_q >= CW'(QUAL_CYC)) begin
               st_d = S_INRUSH;
            end
         end
         S_INRUSH: begin
            cnt_d  = '0;
            step_d = '0;
            if (faultSwitchOn) begin
               st_d = S_SOFT;
            end
         end
         S_SOFT: begin
            cnt_d = cnt_q + CW'(1);
            if (cnt_q >= CW'(SS_STEP_P - 1)) begin
               cnt_d  = '0;
               step_d = step_q + 3'h1;
               if (step_q == 3'(SS_STEPS - 1)) begin
                  st_d = S_RUN;
               end
            end
         end
         S_RUN: begin
            cnt_d = '0;
         end
      endcase
      // Idle time-out and input overcurrent drop everything at once.
      if ((st_q != S_OFF) && (st_q != S_QUAL) && (idleOut || prot.inOverCur)) begin
         st_d = S_OFF;
      end
      gateSink_d = (st_d == S_INRUSH) || (st_d == S_SOFT) || (st_d == S_RUN);
      boostRun_d = (st_d == S_SOFT) || (st_d == S_RUN);
      limitMa_d  = 12'((step_d + 4'h1) * LIMIT_STEP_MA);
      // Compared against the limit already in force this cycle.
      cycleOff_d = boostRun_q && (switchCurMa > limitMa_q);
   end

   always_ff @(posedge clk) begin
      if (rstAll) begin
         st_q       <= S_OFF;
         cnt_q      <= '0;
         idle_q     <= '0;
         step_q     <= '0;
         gateSink_q <= 1'h0;
         boostRun_q <= 1'h0;
         limitMa_q  <= 12'h177;
         cycleOff_q <= 1'h0;
      end else if (clkEn) begin
         st_q       <= st_d;
         cnt_q      <= cnt_d;
         idle_q     <= idle_d;
         step_q     <= step_d;
         gateSink_q <= gateSink_d;
         boostRun_q <= boostRun_d;
         limitMa_q  <= limitMa_d;
         cycleOff_q <= cycleOff_d;
      end
   end

   // Per-channel fault tracking. Current and short faults are only judged while the lamp is on,
   // since current is zero in the dimming off time.
   chanStat_s      stat_d;
   logic [NCH-1:0] chanOn_d;
   logic [CW-1:0]  tmr_q [NCH];
   logic [CW-1:0]  tmr_d [NCH];
   logic [SW-1:0]  fbCode_d;

   always_comb begin
      logic          judge;
      logic [CW-1:0] tmo;
      judge = boostRun_q && enableDimming && prot.ledStable;
      tmo   = prot.hotLow ? CW'(OPEN_HOT_P) : CW'(OPEN_P);
      stat_d   = stat_q;
      chanOn_d = '0;
      for (int i = 0; i < NCH; i++) begin
         tmr_d[i] = tmr_q[i];
         if (judge && above75[i]) begin
            stat_d.good[i] = 1'h1;
         end
         if (judge && stat_q.good[i] && below50[i]) begin
            stat_d.open[i] = 1'h1;
         end
         if (boostRun_q && (prot.overVolt || prot.hotLow) && !stat_q.good[i]) begin
            stat_d.open[i] = 1'h1;
         end
         if (judge && (senseCode[i] > SW'(SHORT_CODE))) begin
            stat_d.off[i] = 1'h1;
         end
         if (stat_q.open[i] && !stat_q.off[i]) begin
            tmr_d[i] = tmr_q[i] + CW'(1);
            if (tmr_q[i] >= tmo - CW'(1)) begin
               stat_d.off[i] = 1'h1;
            end
         end
         // Each channel is gated by the shared run and dimming enables and by its own off flag alone.
         chanOn_d[i] = boostRun_d && enableDimming && !stat_d.off[i];
         if (st_d == S_OFF) begin
            tmr_d[i] = '0;
         end
      end
      if (st_d == S_OFF) begin
         stat_d = '0;
      end
   end

   // Dynamic headroom: the lowest live channel sets the boost feedback.
   always_comb begin
      fbCode_d = '1;
      for (int i = 0; i < NCH; i++) begin
         if (!stat_q.off[i] && (senseCode[i] < fbCode_d)) begin
            fbCode_d = senseCode[i];
         end
      end
      fbValid_d = boostRun_q && (fbCode_d < shortThr);
   end

   always_ff @(posedge clk) begin
      if (rstAll) begin
         stat_q    <= '0;
         chanOn_q  <= '0;
         fbCode_q  <= '0;
         fbValid_q <= 1'h0;
         for (int i = 0; i < NCH; i++) begin
            tmr_q[i] <= '0;
         end
      end else if (clkEn) begin
         stat_q    <= stat_d;
         chanOn_q  <= chanOn_d;
         fbCode_q  <= fbCode_d;
         fbValid_q <= fbValid_d;
         for (int i = 0; i < NCH; i++) begin
            tmr_q[i] <= tmr_d[i];
         end
      end
   end

   // Checks on the sequencer and channel logic.
   default clocking cb @(posedge clk); endclocking
   default disable iff (rstAll);

   a_qual_abort: assert property (clkEn && st_q == S_QUAL && !enableDimming |=> st_q == S_OFF)
      else $error("Short enable pulse was not rejected.");
   a_qual_done: assert property (clkEn && st_q == S_QUAL && enableDimming && cnt_q == CW'(QUAL_CYC)
      |=> st_q == S_INRUSH)
      else $error("Qualified enable pulse did not start inrush.");
   a_idle_shut: assert property (clkEn && boostRun_q && idleOut |=> st_q == S_OFF && !boostRun_q)
      else $error("Idle input did not shut down.");
   a_chop_gate: assert property (clkEn && !enableDimming |=> chanOn_q == '0)
      else $error("Channel on during dimming off time.");
   a_inrush_wait: assert property (clkEn && st_q == S_INRUSH && !faultSwitchOn |=> !boostRun_q)
      else $error("Boost started before fault switch on.");
   a_limit_term: assert property (clkEn && boostRun_q && switchCurMa > limitMa_q |=> cycleOff_q)
      else $error("Overlimit cycle not terminated.");
   a_limit_first: assert property (clkEn && st_q == S_INRUSH && faultSwitchOn && !idleOut
      && !prot.inOverCur |=> limitMa_q == 12'(LIMIT_STEP_MA))
      else $error("Soft-start limit did not begin at first step.");
   a_limit_final: assert property (st_q == S_RUN |-> limitMa_q == 12'((SS_STEPS + 1) * LIMIT_STEP_MA))
      else $error("Final current limit not in force in run.");
   a_short_off: assert property (clkEn && st_q == S_RUN && enableDimming && prot.ledStable
      && !prot.inOverCur && !idleOut && senseCode[0] > SW'(SHORT_CODE) |=> stat_q.off[0])
      else $error("Shorted channel not disabled.");
   a_flags_clear: assert property (clkEn && st_q == S_OFF |=> stat_q == '0)
      else $error("Channel flags survived shutdown.");
   a_fb_valid: assert property ($past(clkEn) && fbValid_q |-> fbCode_q < $past(shortThr))
      else $error("Feedback valid above short threshold.");

   c_enable: cover property (st_q == S_QUAL ##1 st_q == S_INRUSH);
   c_run: cover property (st_q == S_SOFT ##1 st_q == S_RUN);
   c_open_off: cover property (stat_q.open[0] ##1 stat_q.off[0]);
endmodule
`default_nettype wire

/* File: dimming_source_model.sv */
/*
 Behavioural host dimming source driving the combined enable/dimming input.
 Assumes the sequencer clock; the bench keeps the off time under the idle count.
*/
`default_nettype none
module dimming_source_model (
   input  wire logic       clk,
   input  wire logic       pwmOn,
   input  wire logic       holdLvl,
   input  wire logic [7:0] onCyc,
   input  wire logic [7:0] offCyc,
   output var  logic       dim
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] cnt;
   initial begin
      dim = 1'b0;
      cnt = 8'h00;
   end
   // A steady level when idle, else a chopper whose short off time never trips the idle shutdown.
   always @(posedge clk) begin
      if (!pwmOn) begin
         dim <= holdLvl;
         cnt <= 8'h00;
      end else if (cnt == (dim ? onCyc : offCyc)) begin
         dim <= !dim;
         cnt <= 8'h00;
      end else begin
         cnt <= cnt + 8'h01;
      end
   end
endmodule
`default_nettype wire

/* File: tb_top.sv */
/*
 Self-checking bench for the LED string fault sequencer.
 Assumes short timing parameters so the whole run stays a few thousand cycles.
*/
`default_nettype none
module tb_top
   import led_seq_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   localparam int IDLE = 40;
   localparam int STEP = 5;
   localparam int OPN  = 20;
   localparam int HOT  = 6;
   logic clk, rst, clkEn, lock, fsw, pwmOn, holdLvl, dim;
   logic [11:0] cur;
   prot_s prot;
   logic [NCH-1:0][SW-1:0] sense;
   logic [SW-1:0] thr, fbCode_q;
   logic [NCH-1:0] a75, b50, chanOn_q;
   logic gateSink_q, boostRun_q, cycleOff_q, fbValid_q;
   logic [11:0] limitMa_q;
   chanStat_s stat_q;
   int n_errors, n_tests, cycles;
   logic d;

   dimming_source_model host (.clk(clk), .pwmOn(pwmOn), .holdLvl(holdLvl), .onCyc(8'h05), .offCyc(8'h03),
      .dim(dim));
   led_string_fault_sequencer #(.IDLE_P(IDLE), .SS_STEP_P(STEP), .OPEN_P(OPN), .OPEN_HOT_P(HOT)) dut (
      .clk(clk), .rst(rst), .clkEn(clkEn), .supplyLockout(lock), .enableDimming(dim), .faultSwitchOn(fsw),
      .switchCurMa(cur), .prot(prot), .senseCode(sense), .shortThr(thr), .above75(a75), .below50(b50),
      .gateSink_q(gateSink_q), .boostRun_q(boostRun_q), .limitMa_q(limitMa_q), .cycleOff_q(cycleOff_q),
      .chanOn_q(chanOn_q), .fbCode_q(fbCode_q), .fbValid_q(fbValid_q), .stat_q(stat_q));

   // Clock of 50 ns period.
   always #25 clk = !clk;

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      $display("tests=%0d errors=%0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic qual();
      holdLvl <= 1'b1;
      cyc(795);
      @(negedge clk) chk(gateSink_q, 0);
      cyc(20);
      @(negedge clk) chk(gateSink_q, 1);
   endtask
   // A short pulse is refused, then a long one enables.
   task automatic t_start();
      @(posedge clk) holdLvl <= 1'b1;
      cyc(700);
      holdLvl <= 1'b0;
      cyc(120);
      chk(gateSink_q, 0);
      qual();
      $display("t_start done");
   endtask
   task automatic t_soft();
      cyc(20);
      chk(boostRun_q, 0);
      fsw <= 1'b1;
      cyc(1);
      @(negedge clk) chk(boostRun_q, 1);
      chk(limitMa_q, 12'h177);
      cyc(7 * STEP + 5);
      chk(limitMa_q, 12'hBB8);
      cur <= 12'hBB9;
      cyc(3);
      chk(cycleOff_q, 1);
      cur <= 12'hBB8;
      cyc(3);
      chk(cycleOff_q, 0);
      $display("t_soft done");
   endtask
   task automatic t_chan();
      sense[1] <= 10'h020;
      prot.ledStable <= 1'b1;
      a75 <= 6'h3F;
      cyc(3);
      chk(fbCode_q, 10'h020);
      chk(fbValid_q, 1);
      chk(stat_q.good, 6'h3F);
      b50 <= 6'h02;
      cyc(3);
      chk(stat_q.open, 6'h02);
      cyc(OPN + 4);
      chk(stat_q.off, 6'h02);
      chk(chanOn_q, 6'h3D);
      chk(fbCode_q, 10'h030);
      sense[2] <= 10'h0A1;
      cyc(3);
      chk(stat_q.off, 6'h06);
      $display("t_chan done");
   endtask
   // Chopping follows the input one edge later; a long low shuts down and clears flags.
   task automatic t_dim();
      pwmOn <= 1'b1;
      cyc(4);
      repeat (24) begin
         @(negedge clk) d = dim;
         @(negedge clk) chk(chanOn_q, d ? 6'h39 : 6'h00);
      end
      @(posedge clk);
      pwmOn <= 1'b0;
      holdLvl <= 1'b0;
      cyc(IDLE + 5);
      chk(gateSink_q, 0);
      chk(stat_q, 0);
      $display("t_dim done");
   endtask
   task automatic t_hot();
      a75 <= 6'h00;
      b50 <= 6'h00;
      for (int i = 0; i < NCH; i++) sense[i] <= 10'h030;
      qual();
      @(posedge clk);
      prot.hotLow <= 1'b1;
      cyc(2);
      chk(stat_q.open, 6'h3F);
      chk(stat_q.off, 6'h00);
      cyc(HOT + 3);
      chk(stat_q.off, 6'h3F);
      prot.hotLow <= 1'b0;
      prot.inOverCur <= 1'b1;
      cyc(3);
      chk({gateSink_q, boostRun_q, chanOn_q}, 0);
      prot.inOverCur <= 1'b0;
      $display("t_hot done");
   endtask
   task automatic t_lock();
      holdLvl <= 1'b0;
      cyc(5);
      qual();
      @(posedge clk);
      lock <= 1'b1;
      cyc(2);
      chk({gateSink_q, boostRun_q, limitMa_q}, 12'h177);
      lock <= 1'b0;
      holdLvl <= 1'b0;
      cyc(5);
      qual();
      $display("t_lock done");
   endtask

   // A hang counts as a mismatch and ends the run through the normal report.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 10000) begin
         n_errors++;
         test_done();
      end
   end

   initial begin
      {clk, clkEn, lock, fsw, pwmOn, holdLvl, cur, prot, a75, b50} = '0;
      for (int i = 0; i < NCH; i++) sense[i] = 10'h030 + 10'(i * 16);
      thr = 10'h0A0;
      rst = 1'b1;
      clkEn = 1'b1;
      cyc(10);
      rst <= 1'b0;
      t_start();
      t_soft();
      t_chan();
      t_dim();
      t_hot();
      t_lock();
      test_done();
   end
endmodule
`default_nettype wire
